// File: dv/adc_clock_and_sequencer_assertions.sv
// adc_seq_checker: port checks of the converter sequencer
// assumes a single module clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
  input wire logic       I_MCLK,
  input wire logic       I_RESET,
  input wire logic [1:0] I_DIV_SEL,
  input wire logic       I_DIV_LOAD,
  input wire logic [1:0] O_DIV_SEL,
  input wire logic [2:0] O_PHASE,
  input wire logic       O_BUSY,
  input wire logic       O_SAMPLE,
  input wire logic       O_GRANT0,
  input wire logic       O_GRANT1,
  input wire logic [9:0] O_TRIAL,
  input wire logic       O_RESULT_VALID
);
  // every check runs on the module clock, quiet in reset
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  AST_DIV_RST: assert property (
    $fell(I_RESET) |-> O_DIV_SEL == 2'h3) else $error("bad reset sel");
  AST_ORDER: assert property (
    O_PHASE != $past(O_PHASE) |-> O_PHASE == $past(O_PHASE) + 3'h1
    || (O_PHASE == 3'h0 && $past(O_PHASE) == 3'h4)) else $error("order");
  AST_LOAD: assert property (
    I_DIV_LOAD && !O_BUSY |=> O_DIV_SEL == $past(I_DIV_SEL))
    else $error("select not loaded");
  AST_HOLD: assert property (
    O_BUSY |=> O_DIV_SEL == $past(O_DIV_SEL)) else $error("sel moved");
  AST_GRANT: assert property (
    O_GRANT0 || O_GRANT1 |-> O_PHASE == 3'h1 && !(O_GRANT0 && O_GRANT1))
    else $error("bad grant");
  AST_TRIAL: assert property (
    O_PHASE == 3'h3 && $past(O_PHASE) == 3'h2 |-> O_TRIAL == 10'h200)
    else $error("bad first trial");
  AST_VALID: assert property (
    O_RESULT_VALID |-> $past(O_PHASE) == 3'h4 && O_PHASE == 3'h0)
    else $error("valid outside write");
  AST_SAMPLE: assert property (
    O_SAMPLE == (O_PHASE == 3'h2)) else $error("sample level");
  AST_BUSY: assert property (
    O_BUSY == (O_PHASE != 3'h0)) else $error("busy level");
endmodule
bind adc_clock_and_sequencer adc_seq_checker i_chk (.I_MCLK(I_MCLK),
  .I_RESET(I_RESET), .I_DIV_SEL(I_DIV_SEL), .I_DIV_LOAD(I_DIV_LOAD),
  .O_DIV_SEL(O_DIV_SEL), .O_PHASE(O_PHASE), .O_BUSY(O_BUSY),
  .O_SAMPLE(O_SAMPLE), .O_GRANT0(O_GRANT0), .O_GRANT1(O_GRANT1),
  .O_TRIAL(O_TRIAL), .O_RESULT_VALID(O_RESULT_VALID));
`default_nettype wire

// File: dv/analog_core_model.sv
// analog_core_model: ideal comparator of the conversion core
// assumes a held input level and the trial word on the module clock
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  input  wire logic [9:0] i_trial,
  input  wire logic [9:0] i_level,
  output logic            o_cmp
);
  // no settling delay, so any slip in the trial timing shows up
  assign o_cmp = (i_level >= i_trial);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// tb_top: random and corner tests of the converter sequencer
// assumes the ideal comparator model holds the level through a conversion
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_seq_pkg::*;
  logic       clk = 0, rst = 1, ld = 0, r8 = 0, p1 = 0, q0 = 0, q1 = 0;
  logic [1:0] ds = 2'h0, sel = 2'h3, dso;
  logic [3:0] st = 4'h2;
  logic [2:0] c0 = 3'h0, c1 = 3'h0, rch, ach;
  logic [9:0] vin = 10'h000, trial, res;
  logic       cmp, ana, busy, g0, g1, r8o, vld;
  int         seed = 96734, fail_count = 0, tests_run = 0;
  realtime    t0;
  // 125 mhz module clock
  initial begin
    forever #4 clk = ~clk;
  end
  analog_core_model i_core (.i_trial(trial), .i_level(vin), .o_cmp(cmp));
  adc_clock_and_sequencer i_dut (.I_MCLK(clk), .I_RESET(rst),
    .I_DIV_SEL(ds), .I_DIV_LOAD(ld), .I_RES8(r8), .I_SAMPLE_TIME(st),
    .I_PRIO1_HIGH(p1), .I_REQ0(q0), .I_REQ0_CH(c0), .I_REQ1(q1),
    .I_REQ1_CH(c1), .I_CMP(cmp), .O_DIV_SEL(dso), .O_ANA_CLK(ana),
    .O_ANA_CH(ach), .O_SAMPLE(), .O_TRIAL(trial), .O_PHASE(), .O_BUSY(busy),
    .O_GRANT0(g0), .O_GRANT1(g1), .O_RESULT(res), .O_RESULT_CH(rch),
    .O_RESULT_8BIT(r8o), .O_RESULT_VALID(vld));
  function automatic logic [9:0] ratio(input logic [1:0] s);
    return s == 2'h0 ? 10'h2 : s == 2'h1 ? 10'h3 : s == 2'h2 ? 10'h4 : 10'h20;
  endfunction
  function automatic logic [9:0] exp_res(input logic m, input logic [9:0] v);
    return m ? {2'h0, v[9:2]} : v;
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bounded wait; running out of cycles is counted as a mismatch
  task automatic wv();
    int k;
    k = 0;
    @(negedge clk);
    while (vld !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk({9'h0, vld}, 10'h001);
  endtask
  task automatic load(input logic [1:0] s);
    @(posedge clk);
    ds <= s;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  // first period after a load may be cut short, so time a later one
  task automatic per(input logic [1:0] s);
    load(s);
    @(posedge ana);
    @(posedge ana);
    t0 = $realtime;
    @(posedge ana);
    chk(10'(int'(($realtime - t0) / 8.0)), ratio(s));
    $display("period test %0d done", s);
  endtask
  task automatic conv(input logic s, input logic [2:0] ch, input logic m,
                      input logic [9:0] v);
    @(posedge clk);
    r8 <= m;
    vin <= v;
    st <= 4'($random(seed));
    q0 <= !s;
    q1 <= s;
    c0 <= ch;
    c1 <= ch;
    @(posedge clk);
    q0 <= 1'b0;
    q1 <= 1'b0;
    wv();
    chk(res, exp_res(m, v));
    chk({7'h0, rch}, {7'h0, ch});
    chk({9'h0, r8o}, {9'h0, m});
    chk({7'h0, ach}, {7'h0, ch});
    chk({9'h0, busy}, 10'h000);
    $display("conversion test done ch=%0d", ch);
  endtask
  task automatic finish_test();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // margin over eighteen slowest conversions
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  // main sequence: reset, divider codes, conversions, arbitration
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({8'h0, dso}, 10'h3);
    for (int i = 0; i < 4; i++) begin
      per(2'(i));
    end
    conv(1'b0, 3'h7, 1'b0, 10'h3ff);
    conv(1'b1, 3'h0, 1'b1, 10'h000);
    for (int i = 0; i < 12; i++) begin
      // fast codes overrun the analog clock limit at this module clock;
      // the ideal core has no rate limit, so they still check results against exp_res
      sel = 2'($random(seed));
      load(sel);
      conv(1'($random(seed)), 3'($random(seed)), 1'($random(seed)),
           10'($random(seed)));
    end
    $display("random conversions done");
    // both priority settings; the loser must stay pending and run next
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      p1 <= 1'(p);
      q0 <= 1'b1;
      q1 <= 1'b1;
      c0 <= 3'h2;
      c1 <= 3'h5;
      @(posedge clk);
      q0 <= 1'b0;
      q1 <= 1'b0;
      while (!(g0 | g1)) @(negedge clk);
      chk({9'h0, g1}, 10'(p));
      chk({9'h0, g0}, 10'(1 - p));
      chk({9'h0, busy}, 10'h001);
      load(~sel);
      wv();
      chk({7'h0, rch}, p ? 10'h005 : 10'h002);
      chk({8'h0, dso}, {8'h0, sel});
      wv();
      chk({7'h0, rch}, p ? 10'h002 : 10'h005);
    end
    $display("priority test done");
    // mid-run reset must bring a changed select back to divide by 32
    load(2'h1);
    @(negedge clk);
    chk({8'h0, dso}, 10'h001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({8'h0, dso}, 10'h003);
    chk({9'h0, busy}, 10'h000);
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire

// File: logic/adc_clock_and_sequencer.sv
// adc_clock_and_sequencer: prescaler control and conversion phase sequencer
// assumes the analog core and both request sources run on I_MCLK, so the
// comparator answer and requests are same-domain and are not resynchronised
//
// Functional notes
// - results in 8 or 10 bits, eight channels
// - two request sources, programmable priority arbitration
// - analog and digital clocks come from module clock
// - analog clock level given to core for duty
// - divider select 00..11 gives 2,3,4,32
// - divider select resets to divide by 32
// - phases run sync, sample, convert, write in order
`timescale 1ns/1ps
`default_nettype none

module adc_clock_and_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic       I_MCLK,
  input  wire logic       I_RESET,
  input  wire logic [1:0] I_DIV_SEL,
  input  wire logic       I_DIV_LOAD,
  input  wire logic       I_RES8,
  input  wire logic [3:0] I_SAMPLE_TIME,
  input  wire logic       I_PRIO1_HIGH,
  input  wire logic       I_REQ0,
  input  wire logic [2:0] I_REQ0_CH,
  input  wire logic       I_REQ1,
  input  wire logic [2:0] I_REQ1_CH,
  input  wire logic       I_CMP,
  output logic [1:0]      O_DIV_SEL,
  output logic            O_ANA_CLK,
  output logic [2:0]      O_ANA_CH,
  output logic            O_SAMPLE,
  output logic [9:0]      O_TRIAL,
  output logic [2:0]      O_PHASE,
  output logic            O_BUSY,
  output logic            O_GRANT0,
  output logic            O_GRANT1,
  output logic [9:0]      O_RESULT,
  output logic [2:0]      O_RESULT_CH,
  output logic            O_RESULT_8BIT,
  output logic            O_RESULT_VALID
);

  typedef struct packed {
    phase_e     st;
    logic [1:0] div_sel;
    logic       pend0;
    logic [2:0] ch0;
    logic       pend1;
    logic [2:0] ch1;
    logic [2:0] ch;
    logic       res8;
    logic [3:0] tcnt;
    logic [3:0] bitidx;
    logic [9:0] sar;
    logic [9:0] result;
    logic [2:0] result_ch;
    logic       result8;
    logic       valid;
    logic       grant0;
    logic       grant1;
    logic       sample;
    logic       busy;
  } seq_s;

  seq_s       q_r;
  seq_s       q_nxt;
  logic       tick;
  logic       ana_clk;
  logic       take0;
  logic       take1;
  logic [3:0] last_bit;

  // prescaler, one analog tick per divided period
  analog_clock_divider u_div (
    .i_clk     (I_MCLK),
    .i_rst     (I_RESET),
    .i_div_sel (q_r.div_sel),
    .o_tick    (tick),
    .o_clk     (ana_clk)
  );

  // arbitration and phase sequencing
  always_comb begin
    q_nxt        = q_r;
    q_nxt.grant0 = 1'b0;
    q_nxt.grant1 = 1'b0;
    q_nxt.valid  = 1'b0;
    take0        = 1'b0;
    take1        = 1'b0;
    last_bit     = q_r.res8 ? (BITS_10 - BITS_8) : 4'h0;

    // divider select only changes between conversions
    // a load while busy is dropped silently; software has to retry it
    if (I_DIV_LOAD && q_r.st == ST_IDLE) begin
      q_nxt.div_sel = I_DIV_SEL;
    end

    // pick a pending source when idle
    if (q_r.st == ST_IDLE) begin
      if (q_r.pend0 && q_r.pend1) begin
        take1 = I_PRIO1_HIGH;
        take0 = !I_PRIO1_HIGH;
      end else begin
        take0 = q_r.pend0;
        take1 = q_r.pend1;
      end
    end

    // resolution latched at grant so a late mode change cannot split a word
    if (take0 || take1) begin
      q_nxt.ch     = take1 ? q_r.ch1 : q_r.ch0;
      q_nxt.res8   = I_RES8;
      q_nxt.grant0 = take0;
      q_nxt.grant1 = take1;
      q_nxt.pend0  = q_r.pend0 && !take0;
      q_nxt.pend1  = q_r.pend1 && !take1;
      q_nxt.tcnt   = SYNC_TICKS;
      q_nxt.st     = ST_SYNC;
    end

    // new request wins over the grant clearing it
    if (I_REQ0) begin
      q_nxt.pend0 = 1'b1;
      q_nxt.ch0   = I_REQ0_CH;
    end
    if (I_REQ1) begin
      q_nxt.pend1 = 1'b1;
      q_nxt.ch1   = I_REQ1_CH;
    end

    // phases after the grant advance only on analog ticks
    if (tick) begin
      case (q_r.st)
        ST_SYNC: begin
          if (q_r.tcnt <= 4'h1) begin
            q_nxt.st     = ST_SAMPLE;
            q_nxt.sample = 1'b1;
            q_nxt.tcnt   = (I_SAMPLE_TIME < SAMPLE_MIN) ?
                           SAMPLE_MIN : I_SAMPLE_TIME;
          end else begin
            q_nxt.tcnt = q_r.tcnt - 4'h1;
          end
        end
        ST_SAMPLE: begin
          if (q_r.tcnt <= 4'h1) begin
            q_nxt.st     = ST_CONV;
            q_nxt.sample = 1'b0;
            q_nxt.bitidx = MSB_INDEX;
            q_nxt.sar    = 10'h200;
          end else begin
            q_nxt.tcnt = q_r.tcnt - 4'h1;
          end
        end
        ST_CONV: begin
          // keep the trial bit when the input is at or above it
          q_nxt.sar[q_r.bitidx] = I_CMP;
          if (q_r.bitidx == last_bit) begin
            q_nxt.st   = ST_WRITE;
            q_nxt.tcnt = WRITE_TICKS;
          end else begin
            q_nxt.bitidx                 = q_r.bitidx - 4'h1;
            q_nxt.sar[q_r.bitidx - 4'h1] = 1'b1;
          end
        end
        ST_WRITE: begin
          // result and its tags update together with the valid pulse
          if (q_r.tcnt <= 4'h1) begin
            q_nxt.st        = ST_IDLE;
            q_nxt.valid     = 1'b1;
            q_nxt.result_ch = q_r.ch;
            q_nxt.result8   = q_r.res8;
            q_nxt.result    = q_r.res8 ? {2'h0, q_r.sar[9:2]} : q_r.sar;
          end else begin
            q_nxt.tcnt = q_r.tcnt - 4'h1;
          end
        end
        default: begin
          q_nxt.sample = 1'b0;
        end
      endcase
    end

    // busy taken from the next phase so the port is a flop and rises
    // in the grant cycle together with the sync phase
    q_nxt.busy = (q_nxt.st != ST_IDLE);
  end

  // state register; the divider select comes up at divide by 32
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      q_r         <= '0;
      q_r.st      <= ST_IDLE;
      q_r.div_sel <= DIV_SEL_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from flip-flops
  assign O_DIV_SEL      = q_r.div_sel;
  assign O_ANA_CLK      = ana_clk;
  assign O_ANA_CH       = q_r.ch;
  assign O_SAMPLE       = q_r.sample;
  assign O_TRIAL        = q_r.sar;
  assign O_PHASE        = q_r.st;
  assign O_BUSY         = q_r.busy;
  assign O_GRANT0       = q_r.grant0;
  assign O_GRANT1       = q_r.grant1;
  assign O_RESULT       = q_r.result;
  assign O_RESULT_CH    = q_r.result_ch;
  assign O_RESULT_8BIT  = q_r.result8;
  assign O_RESULT_VALID = q_r.valid;

endmodule

`default_nettype wire

// File: logic/adc_seq_pkg.sv
// adc_seq_pkg: constants, states and helpers of the converter sequencer
// assumes one module clock of 125 mhz feeding every part of the block
package adc_seq_pkg;

  // clock and timing base
  localparam int unsigned CLK_PERIOD_NS = 8;

  // divider-select encodings and reset value
  localparam logic [1:0] DIV_SEL_2   = 2'h0;
  localparam logic [1:0] DIV_SEL_3   = 2'h1;
  localparam logic [1:0] DIV_SEL_4   = 2'h2;
  localparam logic [1:0] DIV_SEL_32  = 2'h3;
  localparam logic [1:0] DIV_SEL_RST = DIV_SEL_32;

  // division ratios in module clock cycles
  localparam logic [5:0] RATIO_2  = 6'h02;
  localparam logic [5:0] RATIO_3  = 6'h03;
  localparam logic [5:0] RATIO_4  = 6'h04;
  localparam logic [5:0] RATIO_32 = 6'h20;

  // phase lengths in internal analog clock periods
  localparam logic [3:0] SYNC_TICKS     = 4'h1;
  localparam logic [3:0] WRITE_TICKS    = 4'h1;
  localparam logic [3:0] SAMPLE_MIN     = 4'h2;
  localparam logic [3:0] BITS_10        = 4'ha;
  localparam logic [3:0] BITS_8         = 4'h8;
  localparam logic [3:0] MSB_INDEX      = 4'h9;

  // reset values
  localparam logic [9:0] SAR_RST    = 10'h000;
  localparam logic [2:0] CH_RST     = 3'h0;
  localparam logic [5:0] DIVCNT_RST = 6'h00;

  // conversion phases, also shown on the phase output
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SYNC   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b011,
    ST_WRITE  = 3'b100
  } phase_e;

  // selected division ratio
  function automatic logic [5:0] div_ratio(input logic [1:0] sel);
    case (sel)
      DIV_SEL_2: div_ratio = RATIO_2;
      DIV_SEL_3: div_ratio = RATIO_3;
      DIV_SEL_4: div_ratio = RATIO_4;
      default:   div_ratio = RATIO_32;
    endcase
  endfunction

endpackage

// File: logic/analog_clock_divider.sv
// analog_clock_divider: prescaler from the module clock to the analog clock
// assumes the select input is a registered value on the same clock
`timescale 1ns/1ps
`default_nettype none

module analog_clock_divider
  import adc_seq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_div_sel,
  output logic            o_tick,
  output logic            o_clk
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
    logic       clk;
  } div_s;

  div_s       q_r;
  div_s       q_nxt;
  logic [5:0] ratio;

  // ratio change mid-period wraps at once rather than running to 63
  always_comb begin
    ratio = div_ratio(i_div_sel);
    q_nxt = q_r;
    if (q_r.cnt >= ratio - 6'h01) begin
      q_nxt.cnt = DIVCNT_RST;
    end else begin
      q_nxt.cnt = q_r.cnt + 6'h01;
    end
    q_nxt.tick = (q_nxt.cnt == DIVCNT_RST);
    q_nxt.clk  = (q_nxt.cnt < (ratio >> 1));
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_tick = q_r.tick;
  assign o_clk  = q_r.clk;

endmodule

`default_nettype wire
